// ==== adc_timing_pkg.sv ====
// Constants, register map and carrier types for the converter timing block.
// Assumes a single 40 MHz system clock and a plain strobe register port.
//
// Notes on behaviour
// RULE_01 - Clock skew setting clamps at twenty
// RULE_02 - Wait programmed prescaled periods before converting
// RULE_03 - Timebase is converter clock over prescale+1
// RULE_04 - Results queue four deep; read pops
// RULE_05 - Result read clears all but pen bit
// RULE_06 - Sample reads zero while done clear
// RULE_07 - Polarity travels with sample; zero single-ended
// RULE_08 - Pen bit active low, enabled by 101b
// RULE_09 - Pen bit live, never queued
// RULE_10 - Wake-up is pen OR done; code drives it only while the pen enable (101b) is set
// RULE_11 - Full queue drops newest, sets overrun
// RULE_12 - Done clears on read, rearms next cycle
// RULE_13 - Skew acts on selected module source
// RULE_14 - Interrupt enable gates done onto irq
// RULE_15 - Triggered bit spans the pre-conversion wait
// RULE_16 - Selector 000 pairs channel 0 and 1
// RULE_17 - Zero wait starts on first prescaled edge
// RULE_18 - Empty read returns zeros, pointers kept
package adc_timing_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // Register indices
   localparam logic [2:0] OFS_DELAY_CTRL = 3'h0;
   localparam logic [2:0] OFS_RESULT     = 3'h1;
   localparam logic [2:0] OFS_GEN_CTRL   = 3'h2;
   localparam logic [2:0] OFS_AUX_STAT   = 3'h3;
   localparam logic [2:0] OFS_EVT_STAT   = 3'h4;
   localparam logic [2:0] OFS_EVT_MASK   = 3'h5;

   localparam logic [15:0] DELAY_CTRL_RST = 16'h0000;
   localparam logic [15:0] GEN_CTRL_RST   = 16'h0000;
   localparam logic [15:0] GEN_CTRL_WMASK = 16'h07ff;

   // Aux status field positions
   localparam int AUX_BUSY_BIT = 15;
   localparam int AUX_TRIG_BIT = 14;

   // Event bits
   localparam int EVT_W       = 3;
   localparam int EVT_DONE    = 0;
   localparam int EVT_OVERRUN = 1;
   localparam int EVT_PEN     = 2;
   localparam logic [2:0] EVT_RST = 3'h0;

   localparam logic [4:0] SKEW_MAX     = 5'h14;
   localparam int         SKEW_MAX_NS  = 42;
   localparam logic [2:0] PEN_DETECT_CFG = 3'h5;

   // Converter timebase from the system clock
   localparam int SYS_CLK_KHZ  = 40000;
   localparam int CONV_CLK_KHZ = 12000;
   localparam logic [5:0] CONV_STEP = 6'(CONV_CLK_KHZ / 1000);
   localparam logic [5:0] CONV_DEN  = 6'(SYS_CLK_KHZ / 1000);

   localparam int FIFO_DEPTH = 4;
   localparam int SAMPLE_W   = 12;

   typedef struct packed {
      logic [1:0] prescale;
      logic [8:0] trigger_wait_count;
      logic [4:0] clock_phase_skew;
   } delay_ctrl_t;

   typedef struct packed {
      logic [4:0] unused;
      logic       converter_irq_enable;
      logic [2:0] touchscreen_drive_setting;
      logic [2:0] input_selector_setting;
      logic       diff_mode;
      logic       clk_src_aux;
      logic [1:0] clk_div;
   } gen_ctrl_t;

   typedef struct packed {
      logic       sign;
      logic [11:0] value;
   } fifo_entry_t;

   typedef struct packed {
      logic        done;
      logic        pen_status;
      logic        queue_overrun_flag;
      fifo_entry_t entry;
   } result_port_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_WAIT    = 3'b010,
      ST_CONVERT = 3'b100
   } conv_state_t;

endpackage : adc_timing_pkg

// ==== result_mem.sv ====
// Small result memory with registered read data.
// Assumes the caller owns the pointers and never writes past its depth.
`timescale 1ns/1ps
module result_mem #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   input  wire logic             clk,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule : result_mem

// ==== adc_timing_and_result_fifo.sv ====
// Converter timing, trigger delay and result queue front end.
// Assumes the converter core and trigger logic share clk; pins are async.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module adc_timing_and_result_fifo
   import adc_timing_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic              trigger_event,
   output logic                   conv_start,
   input  wire logic              conv_done,
   input  wire logic [11:0]       conv_value,
   input  wire logic              conv_neg_greater,
   input  wire logic              aux_clk2_pin,
   input  wire logic              pen_detect_pin,
   output logic                   conv_tick,
   output logic      [4:0]        conv_skew,
   output logic      [2:0]        pos_channel,
   output logic      [2:0]        neg_channel,
   output logic                   diff_mode,
   output logic      [2:0]        touchscreen_drive_setting,
   output logic                   converter_wakeup_line,
   output logic                   converter_irq,
   output logic                   event_irq
);

   localparam int AW  = $clog2(DEPTH);
   localparam int CW  = $clog2(DEPTH + 1);
   localparam int EW  = $bits(fifo_entry_t);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   delay_ctrl_t  delay_reg;
   gen_ctrl_t    gen_reg;
   conv_state_t  state_reg;
   logic [8:0]   wait_reg;
   logic         triggered_reg;
   logic         start_reg;
   logic [1:0]   prediv_reg;
   logic [5:0]   acc_reg;
   logic [1:0]   presc_reg;
   logic [1:0]   aux_sync_reg;
   logic         aux_q_reg;
   logic [1:0]   pen_sync_reg;
   logic         pen_q_reg;
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic         done_reg;
   logic         overrun_reg;
   logic [EVT_W-1:0] evt_reg;
   logic [EVT_W-1:0] mask_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [EVT_W-1:0] evt_next;
   fifo_entry_t  head;
   fifo_entry_t  push_entry;
   result_port_t port_view;
   logic [EW-1:0] mem_rd;
   logic         sys_tick;
   logic         acc_tick;
   logic         aux_edge;
   logic         presc_tick;
   logic         rd_result;
   logic         pop;
   logic         push;
   logic         drop;
   logic         pen_en;
   logic         pen_live;

   function automatic logic sel(input logic [ADDR_W-1:0] a,
                                input logic [2:0] ofs);
      sel = (a == ofs);
   endfunction : sel

   assign rd_result = rd_stb && sel(addr, OFS_RESULT);

   // Register writes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         delay_reg <= delay_ctrl_t'(DELAY_CTRL_RST);
         gen_reg   <= gen_ctrl_t'(GEN_CTRL_RST);
         mask_reg  <= EVT_RST;
      end else if (wr_stb) begin
         if (sel(addr, OFS_DELAY_CTRL)) begin
            delay_reg <= delay_ctrl_t'(wdata);
         end
         if (sel(addr, OFS_GEN_CTRL)) begin
            gen_reg <= gen_ctrl_t'(wdata & GEN_CTRL_WMASK);
         end
         if (sel(addr, OFS_EVT_MASK)) begin
            mask_reg <= wdata[EVT_W-1:0];
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         aux_sync_reg <= 2'h0;
         aux_q_reg    <= 1'b0;
         pen_sync_reg <= 2'h0;
         pen_q_reg    <= 1'b0;
      end else begin
         aux_sync_reg <= {aux_sync_reg[0], aux_clk2_pin};
         aux_q_reg    <= aux_sync_reg[1];
         pen_sync_reg <= {pen_sync_reg[0], pen_detect_pin};
         pen_q_reg    <= pen_sync_reg[1];
      end
   end

   assign aux_edge = aux_sync_reg[1] && !aux_q_reg;

   // System clock predivider 1, 2 or 4
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prediv_reg <= 2'h0;
      end else begin
         prediv_reg <= prediv_reg + 2'h1;
      end
   end

   always_comb begin
      case (gen_reg.clk_div)
         2'h0:    sys_tick = 1'b1;
         2'h1:    sys_tick = prediv_reg[0];
         default: sys_tick = (prediv_reg == 2'h3);
      endcase
   end

   // Converter clock rate from the divided system clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         acc_reg <= 6'h00;
      end else if (sys_tick) begin
         if (acc_reg + CONV_STEP >= CONV_DEN) begin
            acc_reg <= acc_reg + CONV_STEP - CONV_DEN;
         end else begin
            acc_reg <= acc_reg + CONV_STEP;
         end
      end
   end

   assign acc_tick = sys_tick && (acc_reg + CONV_STEP >= CONV_DEN);

   // RULE_13 source select
   assign conv_tick = gen_reg.clk_src_aux ? aux_edge : acc_tick;

   // RULE_01 skew clamp
   assign conv_skew = (delay_reg.clock_phase_skew > SKEW_MAX) ?
                      SKEW_MAX : delay_reg.clock_phase_skew;

   // RULE_03 prescaler divide
   always_ff @(posedge clk) begin
      if (!nrst) begin
         presc_reg <= 2'h0;
      end else if (state_reg == ST_IDLE && trigger_event) begin
         presc_reg <= 2'h0;
      end else if (conv_tick) begin
         presc_reg <= (presc_reg == delay_reg.prescale) ?
                      2'h0 : presc_reg + 2'h1;
      end
   end

   assign presc_tick = conv_tick && (presc_reg == delay_reg.prescale);

   // RULE_02 trigger wait sequence
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         wait_reg  <= 9'h000;
         start_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (trigger_event) begin
                  state_reg <= ST_WAIT;
                  wait_reg  <= delay_reg.trigger_wait_count;
               end
            end
            ST_WAIT: begin
               if (presc_tick) begin
                  // RULE_17 zero wait start
                  if (wait_reg == 9'h000) begin
                     state_reg <= ST_CONVERT;
                     start_reg <= 1'b1;
                  end else begin
                     wait_reg <= wait_reg - 9'h001;
                  end
               end
            end
            ST_CONVERT: begin
               if (conv_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   assign conv_start = start_reg;

   // RULE_15 triggered status
   always_ff @(posedge clk) begin
      if (!nrst) begin
         triggered_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && trigger_event) begin
         triggered_reg <= 1'b1;
      end else if (state_reg == ST_CONVERT && conv_done) begin
         triggered_reg <= 1'b0;
      end
   end

   // RULE_16 channel pairing
   assign pos_channel = gen_reg.input_selector_setting;
   assign neg_channel = gen_reg.input_selector_setting ^ 3'h1;
   assign diff_mode   = gen_reg.diff_mode;
   assign touchscreen_drive_setting = gen_reg.touchscreen_drive_setting;

   // RULE_07 polarity only in differential
   assign push_entry.sign  = gen_reg.diff_mode && conv_neg_greater;
   assign push_entry.value = conv_value;

   // RULE_11 full queue drops result
   assign drop = conv_done && (count_reg == FULL_CNT);
   assign push = conv_done && (count_reg != FULL_CNT);
   // RULE_18 empty read keeps pointers
   assign pop  = rd_result && (count_reg != '0);

   // RULE_04 four entry queue
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + CW'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - CW'(1);
         end
      end
   end

   result_mem #(
      .WIDTH (EW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk     (clk),
      .wr_en   (push),
      .wr_addr (wr_ptr_reg),
      .wr_data (push_entry),
      .rd_addr (rd_ptr_reg),
      .rd_data (mem_rd)
   );

   assign head = fifo_entry_t'(mem_rd);

   // RULE_12 done clears then rearms
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_reg <= 1'b0;
      end else if (rd_result) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (count_reg != '0);
      end
   end

   // RULE_11 overrun flag, set wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         overrun_reg <= 1'b0;
      end else if (drop) begin
         overrun_reg <= 1'b1;
      end else if (rd_result) begin
         overrun_reg <= 1'b0;
      end
   end

   // RULE_08 pen enable and active low
   assign pen_en   = (gen_reg.touchscreen_drive_setting == PEN_DETECT_CFG);
   assign pen_live = pen_en && !pen_sync_reg[1];

   // RULE_10 wake-up line
   assign converter_wakeup_line = pen_en && (pen_sync_reg[1] || done_reg);

   // RULE_14 converter interrupt
   assign converter_irq = gen_reg.converter_irq_enable && done_reg;

   // RULE_05 result view cleared by read
   always_comb begin
      port_view.done               = done_reg;
      // RULE_09 live pen bit
      port_view.pen_status         = pen_live;
      port_view.queue_overrun_flag = overrun_reg;
      // RULE_06 zero without done
      port_view.entry              = done_reg ? head : fifo_entry_t'(0);
   end

   // Event status, write one to clear, set wins
   always_comb begin
      evt_next = evt_reg;
      if (wr_stb && sel(addr, OFS_EVT_STAT)) begin
         evt_next = evt_reg & ~wdata[EVT_W-1:0];
      end
      evt_next[EVT_DONE]    = evt_next[EVT_DONE] | push;
      evt_next[EVT_OVERRUN] = evt_next[EVT_OVERRUN] | drop;
      evt_next[EVT_PEN]     = evt_next[EVT_PEN] |
                              (pen_en && pen_sync_reg[1] && !pen_q_reg);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         evt_reg <= EVT_RST;
      end else begin
         evt_reg <= evt_next;
      end
   end

   assign event_irq = |(evt_reg & mask_reg);

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_reg <= 16'h0000;
      end else if (rd_stb) begin
         rdata_reg <= 16'h0000;
         case (addr)
            OFS_DELAY_CTRL: rdata_reg <= delay_reg;
            OFS_RESULT:     rdata_reg <= port_view;
            OFS_GEN_CTRL:   rdata_reg <= gen_reg;
            OFS_AUX_STAT: begin
               rdata_reg[AUX_BUSY_BIT] <= (state_reg == ST_CONVERT);
               rdata_reg[AUX_TRIG_BIT] <= triggered_reg;
               rdata_reg[CW-1:0]       <= count_reg;
            end
            OFS_EVT_STAT:   rdata_reg[EVT_W-1:0] <= evt_reg;
            OFS_EVT_MASK:   rdata_reg[EVT_W-1:0] <= mask_reg;
            default:        rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign rdata = rdata_reg;

   AST_SKEW_CLAMP: // RULE_01
   assert property (@(posedge clk) disable iff (!nrst)
      conv_skew == ((delay_reg.clock_phase_skew > 5'h14) ?
                    5'h14 : delay_reg.clock_phase_skew))
      else $error("skew not clamped at twenty");

   AST_WAIT_DONE: // RULE_02
   assert property (@(posedge clk) disable iff (!nrst)
      (state_reg == ST_WAIT && presc_tick && wait_reg == 9'h000)
      |=> conv_start && state_reg == ST_CONVERT ##1 !conv_start)
      else $error("conversion not started after wait");

   AST_PRESC_TICK: // RULE_03
   assert property (@(posedge clk) disable iff (!nrst)
      presc_tick |-> conv_tick && presc_reg == delay_reg.prescale)
      else $error("prescaled tick off the divider");

   AST_POP_COUNT: // RULE_04
   assert property (@(posedge clk) disable iff (!nrst)
      (pop && !push) |=> count_reg == $past(count_reg) - 3'h1)
      else $error("read did not pop one entry");

   AST_ZERO_NO_DONE: // RULE_06
   assert property (@(posedge clk) disable iff (!nrst)
      rd_result |=> rdata[15] || rdata[12:0] == 13'h0000)
      else $error("sample not zero while done clear");

   AST_SIGN_SINGLE: // RULE_07
   assert property (@(posedge clk) disable iff (!nrst)
      (push && !gen_reg.diff_mode) |-> !push_entry.sign)
      else $error("sign set in single-ended mode");

   AST_PEN_DISABLED: // RULE_08
   assert property (@(posedge clk) disable iff (!nrst)
      (gen_reg.touchscreen_drive_setting != 3'h5) |-> !pen_live
      && !converter_wakeup_line)
      else $error("pen bit or wake active while disabled");

   AST_OVERRUN: // RULE_11
   assert property (@(posedge clk) disable iff (!nrst)
      drop |=> overrun_reg && wr_ptr_reg == $past(wr_ptr_reg))
      else $error("overrun not flagged or entry stored");

   AST_DONE_REARM: // RULE_12
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_result && count_reg > 3'h1) ##1 !rd_result |->
      !done_reg ##1 done_reg)
      else $error("done did not rearm one cycle later");

   AST_IRQ_GATE: // RULE_14
   assert property (@(posedge clk) disable iff (!nrst)
      converter_irq == (gen_reg.converter_irq_enable && done_reg))
      else $error("converter irq not gated by enable");

   AST_TRIG_SPAN: // RULE_15
   assert property (@(posedge clk) disable iff (!nrst)
      (state_reg == ST_CONVERT && conv_done) |=> !triggered_reg
      && state_reg == ST_IDLE)
      else $error("triggered bit not cleared on completion");

   AST_EMPTY_READ: // RULE_18
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_result && count_reg == '0 && !push) |=>
      $stable(rd_ptr_reg) && count_reg == '0)
      else $error("empty read moved the queue");

endmodule : adc_timing_and_result_fifo

// ==== conv_core_model.sv ====
// Behavioural converter core: answers each start with one done pulse.
// Assumes conv_start is a one-cycle pulse on the shared system clock.
`timescale 1ns/1ps
module conv_core_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        conv_start,
   input  wire logic [3:0]  lat,
   input  wire logic [11:0] next_value,
   input  wire logic        next_neg,
   output logic             conv_done,
   output logic [11:0]      conv_value,
   output logic             conv_neg_greater
);
   logic       busy;
   logic [3:0] cnt;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy      <= 1'b0;
         cnt       <= 4'h0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (conv_start) begin
            busy <= 1'b1;
            cnt  <= lat;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               busy      <= 1'b0;
               conv_done <= 1'b1;
            end else begin
               cnt <= cnt - 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (busy && cnt == 4'h0 && !conv_start) begin
         conv_value       <= next_value;
         conv_neg_greater <= next_neg;
      end else begin
         conv_value       <= ~conv_value;
         conv_neg_greater <= ~conv_neg_greater;
      end
   end
endmodule : conv_core_model

// ==== adc_timing_and_result_fifo_test.sv ====
// Self-checking bench: register port, trigger timing, result queue, pen.
// Assumes the core model answers each start; aux clock pin toggles freely.
`timescale 1ns/1ps
module adc_timing_and_result_fifo_test;
   import adc_timing_pkg::*;
   logic              clk, nrst, wr_stb, rd_stb, trigger_event;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic              conv_start, conv_done, conv_neg_greater, conv_tick;
   logic [11:0]       conv_value, next_value;
   logic              next_neg, aux_clk2_pin, pen_detect_pin;
   logic [3:0]        lat;
   logic [4:0]        conv_skew;
   logic [2:0]        pos_channel, neg_channel, touchscreen_drive_setting;
   logic              diff_mode, converter_wakeup_line;
   logic              converter_irq, event_irq;
   int                err_total, n_compared, seed, ovf, dif, pen_en;
   int                q[$];
   int                sk[5] = '{0, 19, 20, 21, 31};

   adc_timing_and_result_fifo u_adc_timing_and_result_fifo (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .trigger_event(trigger_event), .conv_start(conv_start),
      .conv_done(conv_done), .conv_value(conv_value),
      .conv_neg_greater(conv_neg_greater), .aux_clk2_pin(aux_clk2_pin),
      .pen_detect_pin(pen_detect_pin), .conv_tick(conv_tick),
      .conv_skew(conv_skew), .pos_channel(pos_channel),
      .neg_channel(neg_channel), .diff_mode(diff_mode),
      .touchscreen_drive_setting(touchscreen_drive_setting),
      .converter_wakeup_line(converter_wakeup_line),
      .converter_irq(converter_irq), .event_irq(event_irq));

   conv_core_model u_conv_core_model (
      .clk(clk), .nrst(nrst), .conv_start(conv_start), .lat(lat),
      .next_value(next_value), .next_neg(next_neg),
      .conv_done(conv_done), .conv_value(conv_value),
      .conv_neg_greater(conv_neg_greater));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) aux_clk2_pin <= nrst && !aux_clk2_pin;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge clk);
      addr   <= a;
      wdata  <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic res();
      logic [15:0] e;
      e = {q.size() > 0, pen_en[0] & ~pen_detect_pin, ovf[0],
           q.size() > 0 ? q[0][12:0] : 13'h0000};
      if (q.size() > 0)
         void'(q.pop_front());
      ovf = 0;
      rd(OFS_RESULT);
      chk(d, e);
      chk(16'(converter_irq), 16'h0000);
      @(posedge clk);
      #1 chk(16'(converter_irq), 16'(q.size() > 0));
   endtask : res

   task automatic convert(input logic [1:0] p, input logic [8:0] w,
                          input logic [3:0] l);
      int t, n, e;
      t = 0;
      n = 0;
      e = (int'(w) + 1) * (int'(p) + 1);
      wr(OFS_DELAY_CTRL, {p, w, 5'h05});
      @(posedge clk);
      next_value    <= 12'($random(seed));
      next_neg      <= 1'($random(seed));
      lat           <= l;
      trigger_event <= 1'b1;
      @(posedge clk);
      trigger_event <= 1'b0;
      forever begin
         @(negedge clk);
         if (conv_start === 1'b1)
            break;
         if (conv_tick === 1'b1)
            t++;
         n++;
         if (n > 4000) begin
            err_total++;
            tally_and_finish();
         end
      end
      chk(16'(t), 16'(e));
      rd(OFS_AUX_STAT);
      chk(d, 16'hc000 | 16'(q.size()));
      n = 0;
      while (conv_done !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 100) begin
            err_total++;
            tally_and_finish();
         end
      end
      if (q.size() < FIFO_DEPTH)
         q.push_back(int'({dif[0] & next_neg, next_value}));
      else
         ovf = 1;
      repeat (3) @(posedge clk);
      rd(OFS_AUX_STAT);
      chk(d, 16'(q.size()));
   endtask : convert

   initial begin
      seed = 88;
      err_total = 0;
      n_compared = 0;
      ovf = 0;
      dif = 0;
      pen_en = 0;
      nrst = 1'b0;
      addr = 3'h0;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      trigger_event = 1'b0;
      next_value = 12'h000;
      next_neg = 1'b0;
      lat = 4'h3;
      pen_detect_pin = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i));
         chk(d, 16'h0000);
      end
      wr(3'h6, 16'hffff);
      wr(OFS_RESULT, 16'hffff);
      rd(3'h6);
      chk(d, 16'h0000);
      wr(OFS_GEN_CTRL, 16'hffff);
      rd(OFS_GEN_CTRL);
      chk(d, GEN_CTRL_WMASK);
      chk(16'({pos_channel, neg_channel}), 16'h003e);
      wr(OFS_GEN_CTRL, 16'h0408);
      dif = 1;
      #1 chk(16'({pos_channel, neg_channel, diff_mode}), 16'h0003);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_DELAY_CTRL, {2'h1, 9'h1ff, 5'(sk[i])});
         rd(OFS_DELAY_CTRL);
         chk(d, {2'h1, 9'h1ff, 5'(sk[i])});
         chk(16'(conv_skew), 16'(sk[i] > 20 ? 20 : sk[i]));
      end
      wr(OFS_EVT_MASK, 16'h0007);
      convert(2'h2, 9'h003, 4'h5);
      rd(OFS_EVT_STAT);
      chk({d[14:0], event_irq}, 16'h0003);
      wr(OFS_EVT_STAT, 16'h0001);
      #1 chk(16'(event_irq), 16'h0000);
      wr(OFS_GEN_CTRL, 16'h040a);
      convert(2'h0, 9'h000, 4'h9);
      wr(OFS_EVT_MASK, 16'h0000);
      #1 chk(16'(event_irq), 16'h0000);
      wr(OFS_EVT_MASK, 16'h0007);
      #1 chk(16'(event_irq), 16'h0001);
      wr(OFS_GEN_CTRL, 16'h0404);
      dif = 0;
      repeat (3)
         convert(2'($random(seed)), 9'($random(seed) & 15), 4'h2);
      rd(OFS_EVT_STAT);
      chk(d, 16'h0003);
      repeat (5)
         res();
      wr(OFS_GEN_CTRL, 16'h0680);
      pen_en = 1;
      pen_detect_pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(16'(converter_wakeup_line), 16'h0001);
      chk(16'(touchscreen_drive_setting), 16'h0005);
      res();
      @(posedge clk) pen_detect_pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(16'(converter_wakeup_line), 16'h0000);
      res();
      convert(2'h1, 9'h001, 4'h3);
      chk(16'(converter_wakeup_line), 16'h0001);
      res();
      rd(OFS_EVT_STAT);
      chk(d, 16'h0007);
      wr(OFS_EVT_STAT, 16'h0007);
      #1 chk(16'(event_irq), 16'h0000);
      wr(OFS_GEN_CTRL, 16'h0400);
      pen_en = 0;
      pen_detect_pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(16'(converter_wakeup_line), 16'h0000);
      res();
      tally_and_finish();
   end
endmodule : adc_timing_and_result_fifo_test
